// *** ipmu_consts.svh ***
// constants for the interrupt priority and mask unit
`ifndef IPMU_CONSTS_SVH
`define IPMU_CONSTS_SVH

// register indices; byte address is four times the index
`define IPMU_IDX_MASK   8'hdd
`define IPMU_IDX_PRIO   8'hff
`define IPMU_IDX_PEND   8'he0
`define IPMU_IDX_EVST   8'he1
`define IPMU_IDX_EVMK   8'he2
`define IPMU_ADDR_W     12

// reset values
`define IPMU_MASK_RST   8'h00
`define IPMU_PRIO_RST   8'h10
`define IPMU_PEND_RST   8'h00
`define IPMU_EV_RST     3'h0

// priority select field positions
`define IPMU_GRP_HI     7
`define IPMU_GRP_MID    4
`define IPMU_GRP_LO     1
`define IPMU_A_SWAP     0
`define IPMU_B_PAIR     2
`define IPMU_B_SWAP     3
`define IPMU_C_PAIR     5
`define IPMU_C_SWAP     6

// group order codes
`define IPMU_ORD_BCA    3'b001
`define IPMU_ORD_ABC    3'b010
`define IPMU_ORD_BAC    3'b011
`define IPMU_ORD_CAB    3'b100
`define IPMU_ORD_CBA    3'b101
`define IPMU_ORD_ACB    3'b110
`define IPMU_ORD_BAD0   3'b000
`define IPMU_ORD_BAD1   3'b111

// event status bits
`define IPMU_EV_NEWREQ  0
`define IPMU_EV_BADORD  1
`define IPMU_EV_OVERRUN 2
`define IPMU_EV_W       3

// bus responses
`define IPMU_RESP_OKAY   2'b00
`define IPMU_RESP_SLVERR 2'b10

`endif

// *** ipmu_pkg.sv ***
// types shared by the interrupt priority and mask unit
package ipmu_pkg;

    // interrupt level group
    typedef enum logic [1:0] {
        GRP_A = 2'b00,
        GRP_B = 2'b01,
        GRP_C = 2'b10
    } grp_t;

    typedef logic [7:0] level_vec_t;

endpackage

// *** level_resolver.sv ***
// combinational winner pick among eligible interrupt levels
`timescale 1ns/1ps
`default_nettype none
`include "ipmu_consts.svh"

module level_resolver
    import ipmu_pkg::*;
(
    input  wire logic [7:0] req,
    input  wire logic [7:0] prio,
    output logic            any,
    output logic [2:0]      level
);

    // ----------------------------------------------------------------
    // three-member group: one single and one pair
    // ----------------------------------------------------------------
    function automatic logic [1:0] pick3(input logic [2:0] r,
                                         input logic       pair_first,
                                         input logic       swap);
        logic [1:0] pair_w;
        pair_w = swap ? (r[2] ? 2'd2 : 2'd1) : (r[1] ? 2'd1 : 2'd2);
        if (pair_first) begin
            pick3 = (|r[2:1]) ? pair_w : 2'd0;
        end else begin
            pick3 = r[0] ? 2'd0 : pair_w;
        end
    endfunction

    // ----------------------------------------------------------------
    // winners inside each group
    // ----------------------------------------------------------------
    logic [2:0]      win_a;
    logic [2:0]      win_b;
    logic [2:0]      win_c;
    logic [2:0]      grp_any;
    logic [2:0]      code;
    logic [2:0][2:0] win_by_grp;
    grp_t            first;
    grp_t            second;
    grp_t            third;

    // level 0 vs level 1
    assign win_a = prio[`IPMU_A_SWAP] ? (req[1] ? 3'd1 : 3'd0)
                                      : (req[0] ? 3'd0 : 3'd1);
    // level 2 vs pair 3/4
    assign win_b = 3'd2 + {1'b0, pick3(req[4:2], prio[`IPMU_B_PAIR],
                                       prio[`IPMU_B_SWAP])};
    // level 5 vs pair 6/7
    assign win_c = 3'd5 + {1'b0, pick3(req[7:5], prio[`IPMU_C_PAIR],
                                       prio[`IPMU_C_SWAP])};
    assign grp_any = {|req[7:5], |req[4:2], |req[1:0]};
    assign win_by_grp = {win_c, win_b, win_a};
    assign code = {prio[`IPMU_GRP_HI], prio[`IPMU_GRP_MID],
                   prio[`IPMU_GRP_LO]};

    // ----------------------------------------------------------------
    // group order; undefined codes fall back to a fixed order
    // ----------------------------------------------------------------
    always_comb begin
        first  = GRP_A;
        second = GRP_B;
        third  = GRP_C;
        unique case (code)
            `IPMU_ORD_BCA: begin
                first = GRP_B; second = GRP_C; third = GRP_A;
            end
            `IPMU_ORD_BAC: begin
                first = GRP_B; second = GRP_A; third = GRP_C;
            end
            `IPMU_ORD_CAB: begin
                first = GRP_C; second = GRP_A; third = GRP_B;
            end
            `IPMU_ORD_CBA: begin
                first = GRP_C; second = GRP_B; third = GRP_A;
            end
            `IPMU_ORD_ACB: begin
                first = GRP_A; second = GRP_C; third = GRP_B;
            end
            `IPMU_ORD_ABC, `IPMU_ORD_BAD0, `IPMU_ORD_BAD1: begin
                first = GRP_A; second = GRP_B; third = GRP_C;
            end
        endcase
    end

    // highest ranked group with a request supplies the level
    always_comb begin
        any   = |grp_any;
        level = 3'd0;
        if (grp_any[first]) begin
            level = win_by_grp[first];
        end else if (grp_any[second]) begin
            level = win_by_grp[second];
        end else if (grp_any[third]) begin
            level = win_by_grp[third];
        end
    end

endmodule
`default_nettype wire

// *** interrupt_priority_mask_unit.sv ***
// eight-level interrupt priority and mask unit with its register slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ipmu_consts.svh"

module interrupt_priority_mask_unit
    import ipmu_pkg::*;
(
    input  wire logic [11:0] awaddr,
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [7:0]  req_in,
    input  wire logic        cpu_ack,
    input  wire logic [2:0]  cpu_ack_level,
    output logic             irq_valid,
    output logic [2:0]       irq_level,
    output logic             irq
);

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [11:0] A_MASK = {2'b00, `IPMU_IDX_MASK, 2'b00};
    localparam logic [11:0] A_PRIO = {2'b00, `IPMU_IDX_PRIO, 2'b00};
    localparam logic [11:0] A_PEND = {2'b00, `IPMU_IDX_PEND, 2'b00};
    localparam logic [11:0] A_EVST = {2'b00, `IPMU_IDX_EVST, 2'b00};
    localparam logic [11:0] A_EVMK = {2'b00, `IPMU_IDX_EVMK, 2'b00};

    // one-hot select: {evmk, evst, pend, prio, mask}
    function automatic logic [4:0] sel_of(input logic [11:0] a);
        sel_of = {a == A_EVMK, a == A_EVST, a == A_PEND,
                  a == A_PRIO, a == A_MASK};
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic                  aw_held_q;
    logic [11:0]           aw_addr_q;
    logic                  w_held_q;
    logic [7:0]            w_data_q;
    logic                  w_strb_q;
    logic                  bvalid_q;
    logic [1:0]            bresp_q;
    logic                  rvalid_q;
    logic [1:0]            rresp_q;
    logic [31:0]           rdata_q;
    logic [7:0]            mask_q;
    logic [7:0]            prio_q;
    level_vec_t            pend_q;
    logic [`IPMU_EV_W-1:0] evst_q;
    logic [`IPMU_EV_W-1:0] evst_d;
    logic [`IPMU_EV_W-1:0] evmk_q;
    logic                  irq_q;
    logic                  irq_valid_q;
    logic [2:0]            irq_level_q;
    logic [7:0]            elig_prev_q;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic        wr_fire;
    logic [4:0]  wsel;
    logic        wr_ok;
    logic        wr_lane;
    logic        rd_fire;
    logic [4:0]  rsel;
    logic [7:0]  rd_byte;
    logic [2:0]  wr_code;
    logic        wr_bad_code;
    logic [7:0]  elig;
    logic        res_any;
    logic [2:0]  res_level;
    logic [7:0]  ack_vec;
    logic [`IPMU_EV_W-1:0] ev_set;
    logic [`IPMU_EV_W-1:0] ev_clr;

    // address and data may arrive in either order; hold until both
    assign awready = !aw_held_q && !bvalid_q;
    assign wready  = !w_held_q && !bvalid_q;
    assign wr_fire = aw_held_q && w_held_q;
    assign wsel    = sel_of(aw_addr_q);
    assign wr_ok   = |wsel;
    assign wr_lane = wr_fire && w_strb_q;
    assign arready = !rvalid_q;
    assign rd_fire = arvalid && arready;
    assign rsel    = sel_of(araddr);

    // read data mux, low byte only, upper bits read zero
    assign rd_byte = ({8{rsel[0]}} & mask_q)
                   | ({8{rsel[1]}} & prio_q)
                   | ({8{rsel[2]}} & pend_q)
                   | ({8{rsel[3]}} & {5'b0_0000, evst_q})
                   | ({8{rsel[4]}} & {5'b0_0000, evmk_q});

    assign bvalid = bvalid_q;
    assign bresp  = bresp_q;
    assign rvalid = rvalid_q;
    assign rresp  = rresp_q;
    assign rdata  = rdata_q;

    // ----------------------------------------------------------------
    // write channel capture and response
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 12'h000;
        end else if (awvalid && awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= 8'h00;
            w_strb_q <= 1'b0;
        end else if (wvalid && wready) begin
            w_held_q <= 1'b1;
            w_data_q <= wdata[7:0];
            w_strb_q <= wstrb[0];
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // unmapped address answers slverr and changes nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `IPMU_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? `IPMU_RESP_OKAY : `IPMU_RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // read channel: one cycle after the address is taken
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= `IPMU_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= (|rsel) ? `IPMU_RESP_OKAY : `IPMU_RESP_SLVERR;
            rdata_q  <= {24'h00_0000, rd_byte};
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // mask and priority select; pending has no write path
    // ----------------------------------------------------------------
    // defined reset value: all levels masked until software opens them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= `IPMU_MASK_RST;
        end else if (wr_lane && wsel[0]) begin
            mask_q <= w_data_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prio_q <= `IPMU_PRIO_RST;
        end else if (wr_lane && wsel[1]) begin
            prio_q <= w_data_q;
        end
    end

    // an illegal group code is accepted but flagged to software
    assign wr_code = {w_data_q[`IPMU_GRP_HI], w_data_q[`IPMU_GRP_MID],
                      w_data_q[`IPMU_GRP_LO]};
    assign wr_bad_code = wr_lane && wsel[1]
                      && (wr_code == `IPMU_ORD_BAD0
                          || wr_code == `IPMU_ORD_BAD1);

    // ----------------------------------------------------------------
    // pending bits: set by a source pulse, cleared by cpu acknowledge
    // ----------------------------------------------------------------
    assign ack_vec = cpu_ack ? (8'h01 << cpu_ack_level) : 8'h00;

    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_pend
            // a request in the ack cycle keeps the bit set
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pend_q[k] <= 1'(`IPMU_PEND_RST >> k);
                end else begin
                    pend_q[k] <= req_in[k] | (pend_q[k] & ~ack_vec[k]);
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // winner selection towards the cpu
    // ----------------------------------------------------------------
    assign elig = pend_q & mask_q;

    level_resolver u_resolver (
        .req   (elig),
        .prio  (prio_q),
        .any   (res_any),
        .level (res_level)
    );

    // registered so the cpu sees a stable level for a whole cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_valid_q <= 1'b0;
            irq_level_q <= 3'd0;
            elig_prev_q <= 8'h00;
        end else begin
            irq_valid_q <= res_any;
            irq_level_q <= res_level;
            elig_prev_q <= elig;
        end
    end

    assign irq_valid = irq_valid_q;
    assign irq_level = irq_level_q;

    // ----------------------------------------------------------------
    // event status, write one to clear, set wins over clear
    // ----------------------------------------------------------------
    assign ev_set = {|(req_in & pend_q & ~ack_vec), wr_bad_code,
                     |(req_in & ~pend_q)};
    assign ev_clr = (wr_lane && wsel[3]) ? w_data_q[`IPMU_EV_W-1:0]
                                         : 3'h0;
    assign evst_d = (evst_q & ~ev_clr) | ev_set;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evst_q <= `IPMU_EV_RST;
            evmk_q <= `IPMU_EV_RST;
            irq_q  <= 1'b0;
        end else begin
            evst_q <= evst_d;
            if (wr_lane && wsel[4]) begin
                evmk_q <= w_data_q[`IPMU_EV_W-1:0];
            end
            irq_q <= |(evst_d & (wr_lane && wsel[4]
                      ? w_data_q[`IPMU_EV_W-1:0] : evmk_q));
        end
    end

    assign irq = irq_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_masked_not_shown: assert property (
        @(posedge aclk) disable iff (!aresetn)
        irq_valid_q |-> elig_prev_q[irq_level_q])
        else $error("presented level was not pending and unmasked");

    chk_mask_write_stores: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_lane && wsel[0]) |=> mask_q == $past(w_data_q))
        else $error("mask register did not take written value");

    chk_group_a_first: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (prio_q[7] == 1'b0 && prio_q[4] && !prio_q[1] && |elig[1:0])
        |=> irq_valid_q && irq_level_q <= 3'd1)
        else $error("group a not first under order a b c");

    chk_order_c_b_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (prio_q[7] && !prio_q[4] && prio_q[1] && |elig[7:5])
        |=> irq_level_q >= 3'd5)
        else $error("group c not first under order c b a");

    chk_order_b_a_c: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!prio_q[7] && prio_q[4] && prio_q[1] && elig[1:0] != 2'b00
         && elig[4:2] == 3'b000)
        ##1 irq_valid_q |-> irq_level_q <= 3'd1)
        else $error("group a not above c under order b a c");

    chk_a_swap_order: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!prio_q[7] && prio_q[4] && !prio_q[1] && elig[1:0] == 2'b11)
        |=> irq_level_q == ($past(prio_q[0]) ? 3'd1 : 3'd0))
        else $error("group a member order wrong");

    chk_b_pair_order: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!prio_q[7] && !prio_q[4] && prio_q[1] && elig[4:2] == 3'b111)
        |=> irq_level_q == (!$past(prio_q[2]) ? 3'd2 :
                            $past(prio_q[3]) ? 3'd4 : 3'd3))
        else $error("group b member order wrong");

    chk_c_pair_order: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (prio_q[7] && !prio_q[4] && !prio_q[1] && elig[7:5] == 3'b111)
        |=> irq_level_q == (!$past(prio_q[5]) ? 3'd5 :
                            $past(prio_q[6]) ? 3'd7 : 3'd6))
        else $error("group c member order wrong");

    chk_pending_sets: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (|req_in) |=> (pend_q & $past(req_in)) == $past(req_in))
        else $error("request pulse did not set pending bit");

    chk_valid_follows: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (elig == 8'h00) [*2] |-> !irq_valid_q)
        else $error("request presented with nothing eligible");

endmodule
`default_nettype wire

// *** cpu_source_model.sv ***
// cpu core and peripheral request sources facing the priority unit
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// request pulses and presented-level acks
// ----------------------------------------
module cpu_source_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] fire,
    input  wire logic       ack_en,
    input  wire logic       slow,
    input  wire logic       irq_valid,
    input  wire logic [2:0] irq_level,
    output logic [7:0]      req_in,
    output logic            cpu_ack,
    output logic [2:0]      cpu_ack_level
);
    logic [1:0] wait_q;

    // acks only the presented level, then waits for the answer to move
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_in        <= 8'h00;
            cpu_ack       <= 1'b0;
            cpu_ack_level <= 3'h0;
            wait_q        <= 2'h0;
        end else begin
            req_in        <= fire;
            cpu_ack       <= 1'b0;
            cpu_ack_level <= ~cpu_ack_level; // idle lines never hold a level
            if (wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
            end else if (ack_en && irq_valid) begin
                cpu_ack       <= 1'b1;
                cpu_ack_level <= irq_level;
                wait_q        <= slow ? 2'h3 : 2'h2; // lag of the answer
            end
        end
    end
endmodule

`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the interrupt priority and mask unit
`timescale 1ns/1ps
`default_nettype none
`include "ipmu_consts.svh"

module tb_top;
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr  = 12'h000;
    logic        awvalid = 1'b0;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [3:0]  wstrb   = 4'h0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic [11:0] araddr  = 12'h000;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic [7:0]  fire    = 8'h00;
    logic        ack_en  = 1'b0;
    logic        slow    = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        cpu_ack, irq_valid, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  req_in;
    logic [2:0]  cpu_ack_level, irq_level;
    int          miscompares = 0;
    int          compares    = 0;
    localparam logic [1:0]  ok     = `IPMU_RESP_OKAY;
    localparam logic [1:0]  err    = `IPMU_RESP_SLVERR;
    localparam logic [11:0] a_mask = {2'b00, `IPMU_IDX_MASK, 2'b00};
    localparam logic [11:0] a_prio = {2'b00, `IPMU_IDX_PRIO, 2'b00};
    localparam logic [11:0] a_pend = {2'b00, `IPMU_IDX_PEND, 2'b00};
    localparam logic [11:0] a_evst = {2'b00, `IPMU_IDX_EVST, 2'b00};
    localparam logic [11:0] a_evmk = {2'b00, `IPMU_IDX_EVMK, 2'b00};

    always #50 aclk = ~aclk;

    interrupt_priority_mask_unit interrupt_priority_mask_unit_i (
        .awaddr(awaddr), .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .req_in(req_in), .cpu_ack(cpu_ack), .cpu_ack_level(cpu_ack_level),
        .irq_valid(irq_valid), .irq_level(irq_level), .irq(irq));

    cpu_source_model cpu_source_model_i (
        .aclk(aclk), .aresetn(aresetn), .fire(fire), .ack_en(ack_en),
        .slow(slow), .irq_valid(irq_valid), .irq_level(irq_level),
        .req_in(req_in), .cpu_ack(cpu_ack), .cpu_ack_level(cpu_ack_level));

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // each request line high for one cycle
    task automatic pulse(input logic [7:0] v);
        @(posedge aclk);
        fire <= v;
        @(posedge aclk);
        fire <= 8'h00;
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr_chk(input logic [11:0] a, input logic [7:0] d,
                          input logic [1:0] er);
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h00_0000, d};
        wstrb   <= 4'h1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                check(32'(bresp), 32'(er));
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                          input logic [1:0] er);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                check(rdata, exp);
                check(32'(rresp), 32'(er));
                rready <= 1'b0;
                break;
            end
        end
    endtask

    // reference ranking: group order, then subgroup order inside each
    function automatic logic [2:0] top_level(input logic [7:0] p,
                                             input logic [7:0] e);
        int g [3];
        int q [$];
        logic [2:0] r;
        r = 3'h0;
        case ({p[7], p[4], p[1]})
            3'b001:  g = '{1, 2, 0};
            3'b011:  g = '{1, 0, 2};
            3'b100:  g = '{2, 0, 1};
            3'b101:  g = '{2, 1, 0};
            3'b110:  g = '{0, 2, 1};
            default: g = '{0, 1, 2};
        endcase
        foreach (g[i]) begin
            if (g[i] == 0) begin
                q.push_back(int'(p[0]));
                q.push_back(int'(!p[0]));
            end else begin
                if (!p[g[i] * 3 - 1]) q.push_back(g[i] * 3 - 1);
                q.push_back(g[i] * 3 + int'(p[g[i] * 3]));
                q.push_back(g[i] * 3 + 1 - int'(p[g[i] * 3]));
                if (p[g[i] * 3 - 1]) q.push_back(g[i] * 3 - 1);
            end
        end
        for (int i = 7; i >= 0; i--)
            if (e[q[i]]) r = 3'(q[i]);
        return r;
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset();
        rd_chk(a_mask, 32'(`IPMU_MASK_RST), ok);
        rd_chk(a_prio, 32'(`IPMU_PRIO_RST), ok);
        rd_chk(a_pend, 32'(`IPMU_PEND_RST), ok);
        rd_chk(a_evst, 32'h0000_0000, ok);
        rd_chk(a_evmk, 32'h0000_0000, ok);
        rd_chk(12'h000, 32'h0000_0000, err);
        wr_chk(12'h004, 8'hff, err);
        wr_chk(a_pend, 8'hff, ok);
        rd_chk(a_pend, 32'h0000_0000, ok);
        $display("test reset done");
    endtask

    task automatic test_mask();
        pulse(8'h08);
        tick(3);
        check(32'(irq_valid), 32'h0);
        rd_chk(a_pend, 32'h0000_0008, ok);
        wr_chk(a_mask, 8'ha5, ok);
        rd_chk(a_mask, 32'h0000_00a5, ok);
        check(32'(irq_valid), 32'h0);
        wr_chk(a_mask, 8'h08, ok);
        tick(2);
        check(32'(irq_valid), 32'h1);
        check(32'(irq_level), 32'h3);
        slow   <= 1'b1;
        ack_en <= 1'b1;
        tick(8);
        check(32'(irq_valid), 32'h0);
        rd_chk(a_pend, 32'h0000_0000, ok);
        ack_en <= 1'b0;
        $display("test mask done");
    endtask

    // every legal setting against a ladder of masks, all levels pending
    task automatic test_priority();
        logic [7:0] m;
        logic [2:0] t;
        pulse(8'hff);
        for (int p = 0; p < 256; p++) begin
            if (p[7] == p[4] && p[4] == p[1]) continue;
            wr_chk(a_prio, p[7:0], ok);
            for (int k = 0; k < 15; k++) begin
                m = (k < 8) ? 8'hff << k : 8'hff >> (k - 7);
                wr_chk(a_mask, m, ok);
                tick(2);
                check(32'(irq_valid), 32'h1);
                t = top_level(p[7:0], m);
                check(32'(irq_level), 32'(t));
            end
        end
        wr_chk(a_mask, 8'hff, ok);
        slow   <= 1'b0;
        ack_en <= 1'b1;
        tick(40);
        check(32'(irq_valid), 32'h0);
        rd_chk(a_pend, 32'h0000_0000, ok);
        ack_en <= 1'b0;
        $display("test priority done");
    endtask

    task automatic test_events();
        wr_chk(a_mask, 8'h00, ok);
        wr_chk(a_evst, 8'h07, ok);
        rd_chk(a_evst, 32'h0000_0000, ok);
        pulse(8'h04);
        pulse(8'h04);
        tick(2);
        rd_chk(a_evst, 32'h0000_0005, ok);
        check(32'(irq), 32'h0);
        wr_chk(a_evmk, 8'h05, ok);
        tick(2);
        check(32'(irq), 32'h1);
        wr_chk(a_evst, 8'h01, ok);
        rd_chk(a_evst, 32'h0000_0004, ok);
        check(32'(irq), 32'h1);
        wr_chk(a_evst, 8'h04, ok);
        tick(2);
        check(32'(irq), 32'h0);
        wr_chk(a_evmk, 8'h02, ok);
        wr_chk(a_prio, 8'h92, ok);             // illegal group code
        tick(2);
        check(32'(irq), 32'h1);
        rd_chk(a_evst, 32'h0000_0002, ok);
        wr_chk(a_evst, 8'h02, ok);
        tick(2);
        check(32'(irq), 32'h0);
        $display("test events done");
    endtask

    // main sequence; reset held for sixteen cycles
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        test_reset();
        test_mask();
        test_priority();
        test_events();
        print_verdict();
    end

    // watchdog at about twice the expected run of some 20k cycles
    initial begin
        #4_000_000;
        miscompares++;
        print_verdict();
    end
endmodule

`default_nettype wire
